// file: design/ccrc_pkg.sv
// Package: register map, field layout, reset values, mode codes and routing and ladder types of the comparator control block
package ccrc_pkg;

    // ------------------------------------------------------------
    // Register indices and byte addresses (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [9:0] CMP_CTRL_IDX = 10'h019;
    localparam logic [9:0] REF_CTRL_IDX = 10'h099;
    localparam logic [9:0] FLAG_IDX = 10'h00c;
    localparam logic [9:0] DIR_IDX = 10'h085;
    localparam logic [9:0] LEVEL_IDX = 10'h005;
    localparam logic [11:0] CMP_CTRL_ADDR = {CMP_CTRL_IDX, 2'b00};
    localparam logic [11:0] REF_CTRL_ADDR = {REF_CTRL_IDX, 2'b00};
    localparam logic [11:0] FLAG_ADDR = {FLAG_IDX, 2'b00};
    localparam logic [11:0] DIR_ADDR = {DIR_IDX, 2'b00};
    localparam logic [11:0] LEVEL_ADDR = {LEVEL_IDX, 2'b00};

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RESULT_POS = 6;
    localparam int INVERT_POS = 4;
    localparam int SWITCH_POS = 3;
    localparam int POWER_POS = 7;
    localparam int RANGE_POS = 5;
    localparam int FLAG_POS = 3;
    localparam int DIR_POS = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [4:0] CMP_CTRL_RST = 5'h00;
    localparam logic [5:0] REF_CTRL_RST = 6'h00;
    localparam logic DIR_RST = 1'b1;

    // ------------------------------------------------------------
    // Mode codes and routing
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_RESET = 3'b000,
        MODE_PINS_OUT = 3'b001,
        MODE_PINS = 3'b010,
        MODE_REF_OUT = 3'b011,
        MODE_REF = 3'b100,
        MODE_REF_SW_OUT = 3'b101,
        MODE_REF_SW = 3'b110,
        MODE_OFF = 3'b111
    } ccrc_mode_e;

    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_FIRST_PIN = 2'b01,
        SRC_SECOND_PIN = 2'b10,
        SRC_REFERENCE = 2'b11
    } ccrc_src_e;

    // Reference level unit is one ninety-sixth of supply
    localparam logic [6:0] HIGH_BASE = 7'h18;
    localparam logic [6:0] LOW_STEP = 7'h04;
    localparam logic [6:0] HIGH_STEP = 7'h03;

    typedef struct packed {
        logic compOn;
        ccrc_src_e plusSel;
        ccrc_src_e minusSel;
        logic [2:0] analogMask;
        logic drive;
        logic refRouted;
    } ccrc_route_s;

    typedef struct packed {
        logic ladderPower;
        logic ladderRange;
        logic [3:0] ladderTap;
        logic [6:0] levelCode;
    } ccrc_ladder_s;

endpackage

// file: design/ccrc_top.sv
// Comparator and reference ladder control with APB register access
//
// Notes on behaviour
// - Result high when plus input exceeds minus
// - Invert bit four flips reported result
// - Result bit six read-only, resets zero
// - Switch bit steers minus only modes 110/101
// - Three-bit mode field decodes eight modes
// - Mode 111 switches comparator off
// - Reset clears both registers, reset mode
// - Comparator and ladder keep running in sleep
// - Comparator event wakes device from sleep
// - Wake leaves both control registers unchanged
// - Three modes drive result onto pin
// - Pin result passes without clock sync
// - Direction bit enables result pin output
// - Analog-configured pins read zero
// - Four modes route internal reference in
// - Power bit seven enables reference ladder
// - Range bit five: one low, zero high
// - Four-bit tap: sixteen levels per range
// - Low tap/24, high 1/4 plus tap/32
// - Unimplemented control bits read zero
// - Result change sets change flag bit three
// - Comparator control register access ends mismatch condition
// - Software may set or clear change flag
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module ccrc_top #(
    parameter int ADDR_W = 12
) (
    input wire logic ref_clk,                        // System clock, 100 MHz
    input wire logic srst,                           // Synchronous reset, active high
    input wire logic psel,                           // APB select
    input wire logic penable,                        // APB enable
    input wire logic pwrite,                         // APB direction
    input wire logic [ADDR_W-1:0] paddr,             // APB byte address
    input wire logic [31:0] pwdata,                  // APB write data
    input wire logic [3:0] pstrb,                    // APB byte strobes
    output logic [31:0] prdata,                      // APB read data
    output logic pready,                             // APB ready
    output logic pslverr,                            // APB error, unmapped address
    input wire logic compRaw,                        // Analog comparator, high when plus above minus
    input wire logic [2:0] pinLevel,                 // Digital levels of the three port pins
    input wire logic sleepMode,                      // Device asleep
    output logic wakeReq,                            // Wake request from comparator event
    output ccrc_pkg::ccrc_route_s route,             // Comparator input routing and enables
    output ccrc_pkg::ccrc_ladder_s ladder,           // Reference ladder controls
    output logic changeFlag,                         // Compare change flag
    output logic resultPinOut,                       // Result pin level, unclocked
    output logic resultPinOeN                        // Result pin output enable, low drives
);
    import ccrc_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    generate
        if (ADDR_W < 12) begin : g_addr_check
            $error("ADDR_W must be at least 12");
        end
    endgenerate

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] cmpCtrl;
        logic [5:0] refCtrl;
        logic dirBit;
        logic flag;
        logic latched;
        logic rawS1;
        logic rawS2;
        logic [2:0] pinS1;
        logic [2:0] pinS2;
        logic [7:0] rdata;
        logic ready;
        logic slverr;
        ccrc_route_s route;
        ccrc_ladder_s ladder;
        logic oeN;
        logic wake;
    } ccrc_state_s;

    ccrc_state_s cur;
    ccrc_state_s nxt;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    function automatic ccrc_route_s decodeMode(input logic [2:0] mode, input logic sw);
        ccrc_route_s r;
        ccrc_src_e swSrc;
        r = '0;
        swSrc = sw ? SRC_FIRST_PIN : SRC_SECOND_PIN;
        unique case (ccrc_mode_e'(mode))
            MODE_RESET: begin
                r.analogMask = 3'h7;
            end
            MODE_PINS_OUT: begin
                r = '{1'b1, SRC_FIRST_PIN, SRC_SECOND_PIN, 3'h3, 1'b1, 1'b0};
            end
            MODE_PINS: begin
                r = '{1'b1, SRC_FIRST_PIN, SRC_SECOND_PIN, 3'h3, 1'b0, 1'b0};
            end
            MODE_REF_OUT: begin
                r = '{1'b1, SRC_REFERENCE, SRC_SECOND_PIN, 3'h2, 1'b1, 1'b1};
            end
            MODE_REF: begin
                r = '{1'b1, SRC_REFERENCE, SRC_SECOND_PIN, 3'h2, 1'b0, 1'b1};
            end
            MODE_REF_SW_OUT: begin
                r = '{1'b1, SRC_REFERENCE, swSrc, 3'h3, 1'b1, 1'b1};
            end
            MODE_REF_SW: begin
                r = '{1'b1, SRC_REFERENCE, swSrc, 3'h3, 1'b0, 1'b1};
            end
            MODE_OFF: begin
                r = '0;
            end
        endcase
        return r;
    endfunction

    // Ladder level in ninety-sixths of supply
    function automatic ccrc_ladder_s decodeLadder(input logic [5:0] rc);
        ccrc_ladder_s l;
        logic [6:0] tap;
        l = '0;
        tap = {3'h0, rc[3:0]};
        l.ladderPower = rc[5];
        l.ladderRange = rc[4];
        l.ladderTap = rc[3:0];
        if (rc[4]) begin
            l.levelCode = 7'(tap * LOW_STEP);
        end else begin
            l.levelCode = 7'(HIGH_BASE + tap * HIGH_STEP);
        end
        return l;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic setupPh;
    logic accessPh;
    logic [11:0] addr;
    logic highZero;
    logic hitCmp;
    logic hitRef;
    logic hitFlag;
    logic hitDir;
    logic hitLevel;
    logic resultSync;
    logic setEv;
    logic wrLane;

    always_comb begin
        nxt = cur;
        setupPh = psel && !penable;
        accessPh = psel && penable && cur.ready;
        addr = paddr[11:0];
        highZero = (paddr >> 12) == '0;
        hitCmp = highZero && (addr == CMP_CTRL_ADDR);
        hitRef = highZero && (addr == REF_CTRL_ADDR);
        hitFlag = highZero && (addr == FLAG_ADDR);
        hitDir = highZero && (addr == DIR_ADDR);
        hitLevel = highZero && (addr == LEVEL_ADDR);
        wrLane = accessPh && pwrite && pstrb[0];

        // Two-stage synchronisers
        nxt.rawS1 = compRaw;
        nxt.rawS2 = cur.rawS1;
        nxt.pinS1 = pinLevel;
        nxt.pinS2 = cur.pinS1;

        // Reported result, inverted on request, zero while comparator off
        resultSync = cur.route.compOn && (cur.rawS2 ^ cur.cmpCtrl[INVERT_POS]);

        // Mismatch against the value last seen by a comparator control register access
        setEv = resultSync != cur.latched;
        if (accessPh && hitCmp) begin
            nxt.latched = resultSync;
        end

        // Register writes take effect at the access edge
        if (wrLane && hitCmp) begin
            nxt.cmpCtrl = {pwdata[INVERT_POS], pwdata[SWITCH_POS], pwdata[2:0]};
        end
        if (wrLane && hitRef) begin
            nxt.refCtrl = {pwdata[POWER_POS], pwdata[RANGE_POS], pwdata[3:0]};
        end
        if (wrLane && hitDir) begin
            nxt.dirBit = pwdata[DIR_POS];
        end
        if (wrLane && hitFlag) begin
            nxt.flag = pwdata[FLAG_POS];
        end
        if (setEv) begin
            nxt.flag = 1'b1;
        end

        // APB answer: data prepared in setup, ready in the first access cycle
        nxt.ready = 1'b0;
        if (setupPh) begin
            nxt.ready = 1'b1;
            nxt.slverr = !(hitCmp || hitRef || hitFlag || hitDir || hitLevel);
            nxt.rdata = 8'h00;
            if (hitCmp) begin
                nxt.rdata = {1'b0, resultSync, 1'b0, cur.cmpCtrl[4], cur.cmpCtrl[3:0]};
            end
            if (hitRef) begin
                nxt.rdata = {cur.refCtrl[5], 1'b0, cur.refCtrl[4], 1'b0, cur.refCtrl[3:0]};
            end
            if (hitFlag) begin
                nxt.rdata = {4'h0, cur.flag, 3'h0};
            end
            if (hitDir) begin
                nxt.rdata = {5'h00, cur.dirBit, 2'h0};
            end
            if (hitLevel) begin
                nxt.rdata = {5'h00, cur.pinS2 & ~cur.route.analogMask};
            end
        end

        // Decoded controls follow the registers in the same cycle; sleep has no say
        nxt.route = decodeMode(nxt.cmpCtrl[2:0], nxt.cmpCtrl[SWITCH_POS]);
        nxt.ladder = decodeLadder(nxt.refCtrl);
        nxt.oeN = !(nxt.route.drive && !nxt.dirBit);
        nxt.wake = sleepMode && cur.route.compOn && nxt.flag;

        if (srst) begin
            nxt = '0;
            nxt.cmpCtrl = CMP_CTRL_RST;
            nxt.refCtrl = REF_CTRL_RST;
            nxt.dirBit = DIR_RST;
            nxt.route = decodeMode(MODE_RESET, 1'b0);
            nxt.ladder = decodeLadder(REF_CTRL_RST);
            nxt.oeN = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        cur <= nxt;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = {24'h000000, cur.rdata};
    assign pready = cur.ready;
    assign pslverr = cur.slverr;
    assign wakeReq = cur.wake;
    assign route = cur.route;
    assign ladder = cur.ladder;
    assign changeFlag = cur.flag;
    assign resultPinOeN = cur.oeN;
    // Analog result straight to the pin, no clock in the path
    assign resultPinOut = cur.route.drive && (compRaw ^ cur.cmpCtrl[INVERT_POS]);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    reset_values_a: assert property (@(posedge ref_clk) $past(srst) |->
        (cur.cmpCtrl == 5'h00) && (cur.refCtrl == 6'h00) && (route.analogMask == 3'h7) && !ladder.ladderPower)
        else $error("Registers not at reset values after reset");

    mode_off_a: assert property (@(posedge ref_clk) disable iff (srst)
        (cur.cmpCtrl[2:0] == 3'b111) |-> !route.compOn && (route.analogMask == 3'h0))
        else $error("Comparator not off in mode 111");

    output_modes_a: assert property (@(posedge ref_clk) disable iff (srst)
        route.drive == ((cur.cmpCtrl[2:0] == 3'b001) || (cur.cmpCtrl[2:0] == 3'b011) || (cur.cmpCtrl[2:0] == 3'b101)))
        else $error("Result pin drive in wrong mode");

    ref_modes_a: assert property (@(posedge ref_clk) disable iff (srst)
        route.refRouted == ((cur.cmpCtrl[2:0] >= 3'b011) && (cur.cmpCtrl[2:0] <= 3'b110)))
        else $error("Reference routed in wrong mode");

    switch_steer_a: assert property (@(posedge ref_clk) disable iff (srst)
        route.compOn && (route.minusSel != ((cur.cmpCtrl[2:0] inside {3'b101, 3'b110}) && cur.cmpCtrl[3]
        ? SRC_FIRST_PIN : SRC_SECOND_PIN)) |-> 1'b0)
        else $error("Minus input not steered by switch bit");

    read_zero_bits_a: assert property (@(posedge ref_clk) disable iff (srst)
        psel && !penable && !pwrite && (paddr == ADDR_W'(CMP_CTRL_ADDR)) |=> pready && !prdata[7] && !prdata[5])
        else $error("Unimplemented comparator bits read nonzero");

    flag_set_a: assert property (@(posedge ref_clk) disable iff (srst)
        route.compOn && (cur.rawS2 ^ cur.cmpCtrl[4]) != cur.latched |=> changeFlag)
        else $error("Result change did not set flag");

    flag_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
        changeFlag && !(psel && penable && pready && pwrite && (paddr == ADDR_W'(FLAG_ADDR))) |=> changeFlag)
        else $error("Change flag cleared without software write");

    mismatch_end_a: assert property (@(posedge ref_clk) disable iff (srst)
        psel && penable && pready && (paddr == ADDR_W'(CMP_CTRL_ADDR)) |=> cur.latched == $past(resultSync))
        else $error("Control access did not end mismatch");

    wake_event_a: assert property (@(posedge ref_clk) disable iff (srst)
        sleepMode && route.compOn && changeFlag ##1 sleepMode && changeFlag |-> wakeReq)
        else $error("Comparator event did not wake device");

    ladder_level_a: assert property (@(posedge ref_clk) disable iff (srst)
        ladder.levelCode == (ladder.ladderRange ? 7'(ladder.ladderTap * 4) : 7'(24 + ladder.ladderTap * 3)))
        else $error("Reference level code wrong");

    pin_enable_a: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(!resultPinOeN) |-> route.drive && !cur.dirBit)
        else $error("Result pin driven outside output mode");

    result_read_a: assert property (@(posedge ref_clk) disable iff (srst)
        psel && !penable && !pwrite && (paddr == ADDR_W'(CMP_CTRL_ADDR))
        |=> prdata[RESULT_POS] == $past(resultSync))
        else $error("Result bit read differs from synchronised result");

    invert_flip_a: assert property (@(posedge ref_clk) disable iff (srst)
        $changed(cur.cmpCtrl[INVERT_POS]) && route.compOn && $stable(route.compOn) && $stable(cur.rawS2)
        |-> $changed(resultSync))
        else $error("Invert bit did not flip result");

    sync_depth_a: assert property (@(posedge ref_clk) disable iff (srst)
        route.compOn && !cur.cmpCtrl[INVERT_POS] |-> resultSync == $past(compRaw, 2))
        else $error("Result not two stages behind comparator");

    mode_write_a: assert property (@(posedge ref_clk) disable iff (srst)
        psel && penable && pready && pwrite && pstrb[0] && (paddr == ADDR_W'(CMP_CTRL_ADDR))
        |=> cur.cmpCtrl[2:0] == $past(pwdata[2:0]))
        else $error("Mode field not taken from write");

    ladder_power_a: assert property (@(posedge ref_clk) disable iff (srst)
        psel && penable && pready && pwrite && pstrb[0] && (paddr == ADDR_W'(REF_CTRL_ADDR))
        |=> ladder.ladderPower == $past(pwdata[POWER_POS]))
        else $error("Ladder power not taken from write");

    ladder_range_a: assert property (@(posedge ref_clk) disable iff (srst)
        psel && penable && pready && pwrite && pstrb[0] && (paddr == ADDR_W'(REF_CTRL_ADDR))
        |=> ladder.ladderRange == $past(pwdata[RANGE_POS]))
        else $error("Ladder range not taken from write");

    ladder_tap_a: assert property (@(posedge ref_clk) disable iff (srst)
        psel && penable && pready && pwrite && pstrb[0] && (paddr == ADDR_W'(REF_CTRL_ADDR))
        |=> ladder.ladderTap == $past(pwdata[3:0]))
        else $error("Ladder tap not taken from write");

    level_zero_a: assert property (@(posedge ref_clk) disable iff (srst)
        psel && !penable && !pwrite && (paddr == ADDR_W'(LEVEL_ADDR))
        |=> (prdata[2:0] & $past(route.analogMask)) == 3'h0)
        else $error("Analog pin read nonzero");

    sleep_run_a: assert property (@(posedge ref_clk) disable iff (srst)
        sleepMode && !(psel && penable && pready && pwrite) |=> $stable(route) && $stable(ladder))
        else $error("Comparator or ladder changed in sleep");

    sleep_keep_a: assert property (@(posedge ref_clk) disable iff (srst)
        sleepMode && !(psel && penable && pready && pwrite) |=> $stable(cur.cmpCtrl) && $stable(cur.refCtrl))
        else $error("Control registers changed in sleep");

    pin_path_a: assert property (@(posedge ref_clk) disable iff (srst)
        resultPinOut == (route.drive && (compRaw ^ cur.cmpCtrl[INVERT_POS])))
        else $error("Result pin not following comparator");

    reset_mode_a: assert property (@(posedge ref_clk) $past(srst) |->
        !route.compOn && !route.drive && resultPinOeN && !changeFlag && !wakeReq)
        else $error("Outputs not in reset mode after reset");

    wake_quiet_a: assert property (@(posedge ref_clk) disable iff (srst)
        !sleepMode |=> !wakeReq)
        else $error("Wake request while awake");

    flag_sw_set_a: assert property (@(posedge ref_clk) disable iff (srst)
        psel && penable && pready && pwrite && pstrb[0] && pwdata[FLAG_POS] && (paddr == ADDR_W'(FLAG_ADDR))
        |=> changeFlag)
        else $error("Software write did not set flag");

endmodule

// file: bench/ccrc_analog_model.sv
// Behavioural model of the analog comparator, reference ladder and port pins
`timescale 1ns/1ps
module ccrc_analog_model (
    input wire ccrc_pkg::ccrc_route_s route,    // Input routing
    input wire ccrc_pkg::ccrc_ladder_s ladder,  // Ladder controls
    input wire logic [6:0] vPin0,               // First pin, VDD/96 units
    input wire logic [6:0] vPin1,               // Second pin, VDD/96 units
    input wire logic extLevel,                  // Outside level on result pin
    input wire logic resultPinOut,              // Result pin drive value
    input wire logic resultPinOeN,              // Result pin enable, low drives
    output logic compRaw,                       // Comparator output
    output logic [2:0] pinLevel                 // Digital pin levels
);
    import ccrc_pkg::*;
    logic [6:0] refV;
    logic [6:0] plusV;
    logic [6:0] minusV;

    function automatic logic [6:0] pick(ccrc_src_e s, logic [6:0] a, logic [6:0] b, logic [6:0] r);
        return (s == SRC_FIRST_PIN) ? a : (s == SRC_SECOND_PIN) ? b : (s == SRC_REFERENCE) ? r : 7'h00;
    endfunction

    always_comb begin
        refV = ladder.ladderPower ? ladder.levelCode : 7'h00;
        plusV = pick(route.plusSel, vPin0, vPin1, refV);
        minusV = pick(route.minusSel, vPin0, vPin1, refV);
        compRaw = route.compOn & (plusV > minusV);
        pinLevel = {resultPinOeN ? extLevel : resultPinOut, vPin1 >= 7'h30, vPin0 >= 7'h30};
    end
endmodule

// file: bench/testbench.sv
// Testbench: APB checks of comparator and reference ladder control
`timescale 1ns/1ps
module testbench;
    import ccrc_pkg::*;
    logic ref_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, compRaw, wakeReq, changeFlag, resultPinOut, resultPinOeN, err;
    logic sleepMode = 1'b0, extLevel = 1'b0;
    logic [2:0] pinLevel;
    logic [6:0] vPin0 = 7'h00, vPin1 = 7'h00;
    ccrc_route_s route;
    ccrc_ladder_s ladder;
    int errCount = 0, nCompared = 0;

    ccrc_top dut (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .compRaw, .pinLevel, .sleepMode, .wakeReq, .route, .ladder, .changeFlag, .resultPinOut,
        .resultPinOeN);
    ccrc_analog_model partner (.route, .ladder, .vPin0, .vPin1, .extLevel, .resultPinOut, .resultPinOeN,
        .compRaw, .pinLevel);

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [6:0] lvl(logic rng, logic [3:0] tap);
        return rng ? {1'b0, tap, 2'b00} : 7'h18 + 7'(tap) * 7'h03;
    endfunction

    function automatic logic [2:0] amask(logic [2:0] m);
        case (m)
            3'h0: return 3'h7;
            3'h3, 3'h4: return 3'h2;
            3'h7: return 3'h0;
            default: return 3'h3;
        endcase
    endfunction

    function automatic ccrc_src_e plusOf(logic [2:0] m);
        return (m == 3'h0 || m == 3'h7) ? SRC_NONE : (m < 3'h3) ? SRC_FIRST_PIN : SRC_REFERENCE;
    endfunction

    task automatic tallyAndFinish();
        $display("Compared %0d, mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            errCount++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Setup cycle, then access until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            chk("pready", pready, 1'b1);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdChk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask

    task automatic rstChk();
        chk("analogMask", route.analogMask, 3'h7);
        chk("compOn", route.compOn, 1'b0);
        chk("levelCode", ladder.levelCode, lvl(1'b0, 4'h0));
        rdChk("cmpReg", CMP_CTRL_ADDR, 32'h0);
        rdChk("refReg", REF_CTRL_ADDR, 32'h0);
        rdChk("dirReg", DIR_ADDR, 32'h4);
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        errCount++;
        tallyAndFinish();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [2:0] m;
        logic inv, sw, pwr, rng, res;
        logic [3:0] tap;
        logic [6:0] v0, v1, rv, mn;
        void'($urandom(32'h8921));
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        rstChk();
        vPin0 <= 7'h5a;
        vPin1 <= 7'h5a;
        extLevel <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            m = 3'(i);
            wr(CMP_CTRL_ADDR, {29'h0, m});
            repeat (4) @(posedge ref_clk);
            chk("compOn", route.compOn, m != 3'h0 && m != 3'h7);
            chk("analogMask", route.analogMask, amask(m));
            chk("drive", route.drive, m == 3'h1 || m == 3'h3 || m == 3'h5);
            chk("refRouted", route.refRouted, m >= 3'h3 && m <= 3'h6);
            chk("plusSel", route.plusSel, plusOf(m));
            chk("minusSel", route.minusSel, (m == 3'h0 || m == 3'h7) ? SRC_NONE : SRC_SECOND_PIN);
            chk("pinOeN", resultPinOeN, 1'b1);
            rdChk("portLevel", LEVEL_ADDR, {29'h0, ~amask(m)});
        end
        wr(DIR_ADDR, 32'h0);
        for (int i = 0; i < 40; i++) begin
            m = ($urandom_range(1) == 1) ? 3'h5 : 3'h6;
            {inv, sw, pwr, rng, tap} = 8'($urandom);
            v0 = 7'($urandom_range(95));
            v1 = 7'($urandom_range(95));
            vPin0 <= v0;
            vPin1 <= v1;
            wr(REF_CTRL_ADDR, {24'h0, pwr, 1'b0, rng, 1'b0, tap});
            wr(CMP_CTRL_ADDR, {27'h0, inv, sw, m});
            repeat (4) @(posedge ref_clk);
            rv = pwr ? lvl(rng, tap) : 7'h00;
            mn = sw ? v0 : v1;
            res = (rv > mn) ^ inv;
            rdChk("cmpReg", CMP_CTRL_ADDR, {25'h0, res, 1'b0, inv, sw, m});
            chk("levelCode", ladder.levelCode, lvl(rng, tap));
            chk("power", ladder.ladderPower, pwr);
            chk("range", ladder.ladderRange, rng);
            chk("tap", ladder.ladderTap, tap);
            chk("plusSel", route.plusSel, SRC_REFERENCE);
            chk("minusSel", route.minusSel, sw ? SRC_FIRST_PIN : SRC_SECOND_PIN);
            chk("pinOeN", resultPinOeN, m != 3'h5);
            chk("pinOut", resultPinOut, m == 3'h5 && res);
            if (m == 3'h5 && !sw && rv != 7'h00) begin
                vPin1 <= (rv > v1) ? 7'h7f : 7'h00;
                #2;
                chk("pinOutAsync", resultPinOut, !res);
            end
        end
        // Change flag, mismatch and sleep behaviour
        wr(REF_CTRL_ADDR, 32'ha8);
        vPin1 <= 7'h00;
        wr(CMP_CTRL_ADDR, 32'h6);
        repeat (4) @(posedge ref_clk);
        apb(1'b0, CMP_CTRL_ADDR, 32'h0);
        wr(FLAG_ADDR, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk("flag", changeFlag, 1'b0);
        vPin1 <= 7'h5a;
        repeat (5) @(posedge ref_clk);
        chk("flag", changeFlag, 1'b1);
        wr(FLAG_ADDR, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk("flag", changeFlag, 1'b1);
        sleepMode <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("wake", wakeReq, 1'b1);
        vPin1 <= 7'h00;
        repeat (5) @(posedge ref_clk);
        sleepMode <= 1'b0;
        rdChk("cmpReg", CMP_CTRL_ADDR, 32'h46);
        rdChk("refReg", REF_CTRL_ADDR, 32'ha8);
        wr(FLAG_ADDR, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk("flag", changeFlag, 1'b0);
        wr(FLAG_ADDR, 32'h8);
        rdChk("flagReg", FLAG_ADDR, 32'h8);
        // Read-only and unused bits, unmapped place
        wr(CMP_CTRL_ADDR, 32'hff);
        rdChk("cmpReg", CMP_CTRL_ADDR, 32'h1f);
        wr(REF_CTRL_ADDR, 32'hff);
        rdChk("refReg", REF_CTRL_ADDR, 32'haf);
        pstrb <= 4'he;
        wr(REF_CTRL_ADDR, 32'h0);
        pstrb <= 4'hf;
        rdChk("refNoLane", REF_CTRL_ADDR, 32'haf);
        rdChk("unmapped", 12'h000, 32'h0);
        chk("slvErr", err, 1'b1);
        // Second reset in mid-run
        srst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        rstChk();
        tallyAndFinish();
    end
endmodule
